// ==== design/sdrtc_top.sv ====
// SDRAM timing register with refresh scheduler behind an AHB-Lite slave.
//
// Decided for this implementation: the AHB-Lite slave port and the address map.
`include "sdrtc_defines.svh"
module sdrtc_top (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Controller side
	input wire logic access_busy,
	output logic refresh_cmd,
	output logic refresh_active,
	output logic refresh_pending,
	output logic [3:0] refresh_cycles,
	output logic [2:0] precharge_cycles
);
	logic [15:0] timing_q;
	logic wr_pend_q;
	logic [31:0] wr_addr_q;
	logic expire;
	logic pend_q;
	logic [3:0] hold_q;
	sdrtc_pkg::sdrtc_state_e state_q;
	logic [3:0] rc_cycles;
	logic [2:0] rp_cycles;

	// Address phase of a transfer aimed at this slave
	function automatic logic bus_select(input logic sel, input logic [1:0] trans);
		return sel && trans[`SDRTC_HTRANS_NONSEQ_BIT];
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Bus slave: zero wait states, always OKAY
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	// Capture write address phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 32'h0000_0000;
		end else if (hready) begin
			wr_pend_q <= bus_select(hsel, htrans) && hwrite;
			wr_addr_q <= haddr;
		end
	end

	// Timing register; reserved bits 7:6 are not writable
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			timing_q <= `SDRTC_TIMING_RESET;
		end else if (wr_pend_q && wr_addr_q == `SDRTC_TIMING_OFFSET) begin
			timing_q <= (hwdata[15:0] & `SDRTC_WRITE_MASK)
				| (`SDRTC_TIMING_RESET & ~`SDRTC_WRITE_MASK);
		end
	end

	// Read data registered in the data phase; unmapped reads give zero
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (hready && bus_select(hsel, htrans) && !hwrite) begin
			if (haddr == `SDRTC_TIMING_OFFSET) begin
				hrdata <= {16'h0000, timing_q};
			end else if (haddr == `SDRTC_STATUS_OFFSET) begin
				hrdata <= {28'h0000000, 1'b0, state_q == sdrtc_pkg::SDRTC_REFRESH,
					pend_q, refresh_cmd};
			end else begin
				hrdata <= 32'h0000_0000;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Interval timer
	sdrtc_interval u_interval (
		.hclk(hclk),
		.hresetn(hresetn),
		.prescale(timing_q[`SDRTC_RTP_HI:`SDRTC_RTP_LO]),
		.expire(expire)
	);

	// Cycle counts derived from the fields
	assign rc_cycles = {2'b00, timing_q[`SDRTC_RC_HI:`SDRTC_RC_LO]} + `SDRTC_RC_BASE;
	assign rp_cycles = {1'b0, timing_q[`SDRTC_RP_HI:`SDRTC_RP_LO]} + `SDRTC_RP_BASE;

	// Pending request; a new expiry wins over the clear at refresh start
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pend_q <= 1'b0;
		end else if (expire) begin
			pend_q <= 1'b1;
		end else if (state_q == sdrtc_pkg::SDRTC_IDLE && pend_q && !access_busy) begin
			pend_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Refresh sequencer: command in the first cycle, then hold
	// The hold counter leaves at one, so loading the full count gives rc+5 active cycles
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q <= sdrtc_pkg::SDRTC_IDLE;
			hold_q <= 4'h0;
			refresh_cmd <= 1'b0;
		end else begin
			refresh_cmd <= 1'b0;
			unique case (state_q)
				sdrtc_pkg::SDRTC_IDLE: begin
					if (pend_q && !access_busy) begin
						state_q <= sdrtc_pkg::SDRTC_REFRESH;
						refresh_cmd <= 1'b1;
						hold_q <= rc_cycles;
					end
				end
				sdrtc_pkg::SDRTC_REFRESH: begin
					if (hold_q <= 4'h1) begin
						state_q <= sdrtc_pkg::SDRTC_IDLE;
					end
					hold_q <= hold_q - 4'h1;
				end
				default: begin
					state_q <= sdrtc_pkg::SDRTC_IDLE;
				end
			endcase
		end
	end

	// Outputs to the controller
	assign refresh_active = (state_q == sdrtc_pkg::SDRTC_REFRESH);
	assign refresh_pending = pend_q;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			refresh_cycles <= 4'h0;
			precharge_cycles <= 3'h0;
		end else begin
			refresh_cycles <= rc_cycles;
			precharge_cycles <= rp_cycles;
		end
	end
endmodule

// ==== design/sdrtc_defines.svh ====
// Constants of the SDRAM refresh and timing configuration block.
// What this block does
// - A refresh is requested every prescale-field times 16 clock cycles, or every 16 cycles for a field of zero.
// - The refresh state lasts the refresh hold count plus five cycles.
// - The refresh command goes out in the first refresh-state cycle; the rest is a wait.
// - A precharge lasts the precharge count plus one cycle.
// - The timing register resets to 0x2115.
`ifndef SDRTC_DEFINES_SVH
`define SDRTC_DEFINES_SVH
`define SDRTC_TIMING_OFFSET 32'h0000_0000
`define SDRTC_STATUS_OFFSET 32'h0000_0004
`define SDRTC_TIMING_RESET 16'h2115
`define SDRTC_RTP_HI 15
`define SDRTC_RTP_LO 10
`define SDRTC_RC_HI 9
`define SDRTC_RC_LO 8
`define SDRTC_RP_HI 5
`define SDRTC_RP_LO 4
`define SDRTC_WRITE_MASK 16'hFF3F
`define SDRTC_TICK_DIV 4'hF
`define SDRTC_RC_BASE 4'h5
`define SDRTC_RP_BASE 3'h1
`define SDRTC_HTRANS_NONSEQ_BIT 1
`endif

// ==== design/sdrtc_pkg.sv ====
// Types of the SDRAM refresh and timing configuration block.
package sdrtc_pkg;
	typedef enum logic [1:0] {
		SDRTC_IDLE = 2'b00,
		SDRTC_WAIT = 2'b01,
		SDRTC_REFRESH = 2'b10
	} sdrtc_state_e;
endpackage

// ==== design/sdrtc_interval.sv ====
// Refresh interval timer: divide by 16, then count the prescale value.
`include "sdrtc_defines.svh"
module sdrtc_interval (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Prescale field
	input wire logic [5:0] prescale,
	// One-cycle pulse when the interval ends
	output logic expire
);
	logic [3:0] div_q;
	logic [5:0] cnt_q;
	logic tick;

	// Sixteen-cycle enable pulse
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div_q <= 4'h0;
		end else begin
			div_q <= div_q + 4'h1;
		end
	end
	assign tick = (div_q == `SDRTC_TICK_DIV);

	// Counts ticks down; a prescale of zero is treated as one tick
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_q <= 6'h00;
		end else if (tick) begin
			if (cnt_q <= 6'h01) begin
				cnt_q <= prescale;
			end else begin
				cnt_q <= cnt_q - 6'h01;
			end
		end
	end
	assign expire = tick && (cnt_q <= 6'h01);
endmodule

// ==== tb/sdrtc_checker.sv ====
// Port checks of the refresh scheduler.
module sdrtc_checker (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Watched ports
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic access_busy,
	input wire logic refresh_cmd,
	input wire logic refresh_active,
	input wire logic refresh_pending,
	input wire logic [3:0] refresh_cycles
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic [3:0] cnt_q;
	logic [3:0] len_q;
	////////////////////////////////////////////////////////////
	// Refresh length seen, and the target latched at the command so late writes do not move it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_q <= 4'h0;
			len_q <= 4'h0;
		end else begin
			cnt_q <= refresh_active ? cnt_q + 4'h1 : 4'h0;
			len_q <= refresh_cmd ? refresh_cycles : len_q;
		end
	end
	bus_okay_a: assert property (hreadyout && !hresp) else $error("bus stall");
	cmd_pulse_a: assert property (refresh_cmd |=> !refresh_cmd) else $error("cmd");
	cmd_first_a: assert property (refresh_cmd == $rose(refresh_active)) else $error("c");
	hold_min_a: assert property ($rose(refresh_active) |-> refresh_active[*5]) else $error("h");
	hold_len_a: assert property ($fell(refresh_active) |-> cnt_q == len_q) else $error("l");
	refresh_start_a: assert property (refresh_pending && !access_busy && !refresh_active |=> refresh_cmd) else $error("s");
	busy_wait_a: assert property (access_busy |=> !refresh_cmd) else $error("b");
	cmd_cause_a: assert property (refresh_cmd |-> $past(refresh_pending)) else $error("p");
endmodule
bind sdrtc_top sdrtc_checker chk_u (.hclk, .hresetn, .hreadyout, .hresp, .access_busy,
	.refresh_cmd, .refresh_active, .refresh_pending, .refresh_cycles);

// ==== tb/sdrtc_sdram_model.sv ====
// SDRAM side model: one access keeps the controller busy.
module sdrtc_sdram_model (
	// Clock, reset, access start
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic start,
	// Access in progress
	output logic access_busy
);
	timeunit 1ns;
	timeprecision 1ps;
	int left_q;
	// An access lasts 50 cycles; a refresh has to wait it out
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) left_q <= 0;
		else left_q <= start ? 50 : (left_q > 0 ? left_q - 1 : 0);
	end
	assign access_busy = left_q > 0;
endmodule

// ==== tb/tb_sdram_refresh_timing_config.sv ====
// Bench of the timing register and refresh scheduler.
module tb_sdram_refresh_timing_config;
	timeunit 1ns;
	timeprecision 1ps;
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, go = 0;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
	logic [1:0] htrans = 0;
	logic hreadyout, hresp, access_busy, refresh_cmd, refresh_active, refresh_pending;
	logic [3:0] refresh_cycles;
	logic [2:0] precharge_cycles;
	int err_total = 0, checks_done = 0, cyc = 0, n;
	always #2 hclk = ~hclk;
	sdrtc_top dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
		.hready(hreadyout), .hreadyout, .hresp, .hrdata, .access_busy, .refresh_cmd,
		.refresh_active, .refresh_pending, .refresh_cycles, .precharge_cycles);
	sdrtc_sdram_model mem_u (.hclk, .hresetn, .start(go), .access_busy);
	////////////////////////////////////////////////////////////
	task chk(string s, logic [31:0] e, logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			err_total++;
			$display("wrong value %s exp %h got %h", s, e, g);
		end
	endtask
	// One single transfer; the data phase waits for ready as well
	task ahb(logic w, logic [31:0] a, logic [31:0] d);
		{hsel, htrans, hwrite, haddr} <= {1'h1, 2'h2, w, a};
		do @(posedge hclk); while (hreadyout !== 1);
		{hsel, htrans, hwdata} <= {1'h0, 2'h0, d};
		do @(posedge hclk); while (hreadyout !== 1);
		rd = hrdata;
	endtask
	task wait_cmd;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (refresh_cmd !== 1 && n < 300);
	endtask
	task final_report;
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	////////////////////////////////////////////////////////////
	task t_reset;
		ahb(0, 32'h0, 32'h0);
		chk("timing", 32'h2115, rd);
		chk("hold", 32'h6, 32'(refresh_cycles));
		ahb(0, 32'h8, 32'h0);
		chk("unmapped", 32'h0, rd);
	endtask
	// Every hold and precharge code, reserved bits written as zero
	task t_fields;
		for (int i = 0; i < 16; i++) begin
			ahb(1, 32'h0, {16'h0, 6'h08, i[3:2], 2'h0, i[1:0], 4'h5});
			ahb(0, 32'h0, 32'h0);
			chk("readback", {16'h0, 6'h08, i[3:2], 2'h0, i[1:0], 4'h5}, rd);
			chk("hold", 32'(i[3:2]) + 32'h5, 32'(refresh_cycles));
			chk("pre", 32'(i[1:0]) + 32'h1, 32'(precharge_cycles));
		end
	endtask
	// The first gap may still run on the old prescale, so only the last one is judged
	task t_interval;
		ahb(1, 32'h0, 32'h0B05);
		wait_cmd();
		wait_cmd();
		wait_cmd();
		chk("gap", 32'd32, n);
		chk("short pre", 32'h1, 32'(precharge_cycles));
	endtask
	// Expiry lands during an access: request waits, then goes once the access ends
	task t_busy;
		wait_cmd();
		go <= 1;
		@(posedge hclk);
		go <= 0;
		repeat (38) @(posedge hclk);
		ahb(0, 32'h4, 32'h0);
		chk("status", 32'h2, rd);
		@(posedge hclk);
		chk("pending", 32'h1, 32'(refresh_pending));
		wait_cmd();
		chk("late", 32'h1, 32'(n >= 11 && n <= 13));
	endtask
	// Cut a hang short
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 5000) begin
			err_total++;
			final_report();
		end
	end
	initial begin
		repeat (2) @(posedge hclk);
		hresetn <= 1;
		@(posedge hclk);
		t_reset();
		t_fields();
		t_interval();
		t_busy();
		final_report();
	end
endmodule
